/* src/sds_pkg.sv */
// Shared constants and types for the synthesizer, divider, skew and master clock control.
`default_nettype none

package sds_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NSYN     = 4;
	localparam int NDIV     = 4;
	localparam int FINE_W   = 8;
	localparam int CRS_W    = 14;
	localparam int NREF     = 8;
	localparam int MHZ_W    = 26;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [11:0] SYN_STRIDE = 12'h040;
	localparam logic [3:0]  IX_B       = 4'h0;
	localparam logic [3:0]  IX_K       = 4'h1;
	localparam logic [3:0]  IX_M       = 4'h2;
	localparam logic [3:0]  IX_N       = 4'h3;
	localparam logic [3:0]  IX_FINE    = 4'h4;
	localparam logic [3:0]  IX_CRS0    = 4'h5;
	localparam logic [3:0]  IX_CRS1    = 4'h6;
	localparam logic [3:0]  IX_DIV0    = 4'h7;
	localparam logic [3:0]  IX_LAST    = 4'hA;
	localparam logic [11:0] ADDR_REF   = 12'h100;
	localparam logic [11:0] ADDR_CFO   = 12'h104;
	localparam logic [11:0] ADDR_STAT  = 12'h108;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] RST_BKMN   = 16'h0001;
	localparam logic [31:0] RST_DIV    = 32'h00000001;
	localparam logic [31:0] RST_CFO    = 32'h046AAAAB;
	localparam logic [7:0]  RST_REF    = 8'h00;

	// ----------------------------------------
	// Frequencies in hertz, frequency multiplier and coarse skew limit
	// ----------------------------------------
	localparam logic [79:0] FREQ_MUL   = 80'h10;
	localparam logic [79:0] FSYN_MIN   = 80'h3B9ACA00;
	localparam logic [79:0] FSYN_MAX   = 80'h59682F00;
	localparam logic [79:0] FDIFF_MAX  = 80'h2CB41780;
	localparam logic [79:0] FSE_MAX    = 80'hA946F60;
	localparam logic [MHZ_W-1:0] HZ_24M = 26'h1770000;
	localparam logic [MHZ_W-1:0] HZ_49M = 26'h2EE0000;
	localparam logic [MHZ_W-1:0] HZ_20M = 26'h1312D00;
	localparam logic signed [CRS_W-1:0] CRS_MAX = 14'sh1000;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ   = 125;
	localparam int STRAP_MS  = 125;
	localparam int STRAP_CYC = STRAP_MS * 1000 * CLK_MHZ;
	localparam logic [31:0] SYNC_CYC = 32'h00000003;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		MCLK_24M  = 2'b00,
		MCLK_49M  = 2'b01,
		MCLK_20M  = 2'b10,
		MCLK_RSVD = 2'b11
	} sds_mclk_t;

	typedef enum logic [1:0] {
		ST_SYNC = 2'b00,
		ST_HOLD = 2'b01,
		ST_GPIO = 2'b10
	} sds_st_t;

endpackage

`default_nettype wire

/* src/sds_synth_ctrl.sv */
// Synthesizer frequency, divider, skew, reference type and master clock select control.
//
// Chosen here: the register addresses and the APB slave port.
`default_nettype none

// Summary of operation
// - Synth frequency is 16*B*K*M/N hertz
// - Synthesizer supports 1 to 1.5 GHz
// - Four dividers: two differential, two single-ended
// - Fine phase shifts all four outputs
// - Fine advance in 256 period steps
// - Coarse skew per single-ended output, +/-4096
// - References reset single-ended, software selects differential
// - Select pins sampled after reset release
// - Decode select pins into master clock
// - Master clock is the 0 ppm reference

module sds_synth_ctrl #(
	parameter int STRAP_CYCLES = sds_pkg::STRAP_CYC
) (
	input  wire logic                    i_clk,
	input  wire logic                    i_arst_n,
	input  wire logic                    i_psel,
	input  wire logic                    i_penable,
	input  wire logic                    i_pwrite,
	input  wire logic [11:0]             i_paddr,
	input  wire logic [31:0]             i_pwdata,
	output logic      [31:0]             o_prdata,
	output logic                         o_pready,
	output logic                         o_pslverr,
	input  wire logic [1:0]              i_mclk_sel_pin,
	output logic      [1:0]              o_mclk_sel,
	output logic      [sds_pkg::MHZ_W-1:0] o_mclk_hz,
	output logic                         o_mclk_valid,
	output logic                         o_mclk_invalid,
	output logic                         o_strap_window,
	output logic      [sds_pkg::NREF-1:0] o_ref_diff,
	output logic      [31:0]             o_cfo,
	output logic      [4*16*sds_pkg::NSYN-1:0] o_synth_bkmn,
	output logic      [sds_pkg::NSYN-1:0] o_synth_ok,
	output logic      [32*16-1:0]        o_div_ratio,
	output logic      [15:0]             o_div_ok,
	output logic      [16*sds_pkg::FINE_W-1:0] o_out_fine,
	output logic      [8*sds_pkg::CRS_W-1:0] o_se_coarse
);
	import sds_pkg::*;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [79:0] syn_num(input logic [15:0] b, input logic [15:0] k,
		input logic [15:0] m);
		return 80'(b) * 80'(k) * 80'(m) * FREQ_MUL;
	endfunction

	function automatic logic syn_in_range(input logic [79:0] num, input logic [15:0] n);
		return (n != 16'h0000) && (num >= 80'(n) * FSYN_MIN) && (num <= 80'(n) * FSYN_MAX);
	endfunction

	function automatic logic div_in_range(input logic [79:0] num, input logic [15:0] n,
		input logic [31:0] r, input logic [79:0] fmax);
		return (r != 32'h00000000) && (num <= 80'(n) * 80'(r) * fmax);
	endfunction

	function automatic logic [CRS_W-1:0] crs_clamp(input logic signed [31:0] v);
		logic signed [31:0] lim;
		lim = 32'(CRS_MAX);
		if (v > lim) begin
			return CRS_MAX;
		end else if (v < -lim) begin
			return -CRS_MAX;
		end
		return v[CRS_W-1:0];
	endfunction

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [15:0]       bkmn_reg [16];
	logic [15:0]       bkmn_next [16];
	logic [FINE_W-1:0] fine_reg [NSYN];
	logic [FINE_W-1:0] fine_next [NSYN];
	logic [CRS_W-1:0]  crs_reg [8];
	logic [CRS_W-1:0]  crs_next [8];
	logic [31:0]       div_reg [16];
	logic [31:0]       div_next [16];
	logic [NREF-1:0]   ref_reg;
	logic [NREF-1:0]   ref_next;
	logic [31:0]       cfo_reg;
	logic [31:0]       cfo_next;
	logic [31:0]       rdata_reg;
	logic [31:0]       rdata_next;
	logic [31:0]       rd_val;

	logic [1:0] sidx;
	logic [3:0] ix;
	logic       syn_hit;
	logic       glb_hit;
	logic       wr_en;
	logic [1:0] dix;

	assign sidx    = i_paddr[7:6];
	assign ix      = i_paddr[5:2];
	assign dix     = 2'(ix - IX_DIV0);
	assign syn_hit = (i_paddr[11:8] == 4'h0) && (ix <= IX_LAST) && (i_paddr[1:0] == 2'b00);
	assign glb_hit = (i_paddr == ADDR_REF) || (i_paddr == ADDR_CFO) || (i_paddr == ADDR_STAT);
	assign wr_en   = i_psel && i_penable && i_pwrite;

	// ----------------------------------------
	// Configuration writes
	// ----------------------------------------
	always_comb begin
		bkmn_next = bkmn_reg;
		fine_next = fine_reg;
		crs_next  = crs_reg;
		div_next  = div_reg;
		ref_next  = ref_reg;
		cfo_next  = cfo_reg;
		if (wr_en && syn_hit) begin
			case (ix)
				IX_B, IX_K, IX_M, IX_N: begin
					bkmn_next[{sidx, ix[1:0]}] = i_pwdata[15:0];
				end
				IX_FINE: begin
					fine_next[sidx] = i_pwdata[FINE_W-1:0];
				end
				IX_CRS0, IX_CRS1: begin
					crs_next[{sidx, ix == IX_CRS1}] = crs_clamp(i_pwdata);
				end
				default: begin
					div_next[{sidx, dix}] = i_pwdata;
				end
			endcase
		end
		if (wr_en && (i_paddr == ADDR_REF)) begin
			ref_next = i_pwdata[NREF-1:0];
		end
		if (wr_en && (i_paddr == ADDR_CFO)) begin
			cfo_next = i_pwdata;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			for (int i = 0; i < 16; i++) begin
				bkmn_reg[i] <= RST_BKMN;
				div_reg[i]  <= RST_DIV;
			end
			for (int i = 0; i < NSYN; i++) begin
				fine_reg[i] <= '0;
			end
			for (int i = 0; i < 8; i++) begin
				crs_reg[i] <= '0;
			end
			ref_reg <= RST_REF;
			cfo_reg <= RST_CFO;
		end else begin
			bkmn_reg <= bkmn_next;
			div_reg  <= div_next;
			fine_reg <= fine_next;
			crs_reg  <= crs_next;
			ref_reg  <= ref_next;
			cfo_reg  <= cfo_next;
		end
	end

	// ----------------------------------------
	// Frequency checks
	// ----------------------------------------
	logic [79:0] num [NSYN];

	always_comb begin
		for (int s = 0; s < NSYN; s++) begin
			num[s] = syn_num(bkmn_reg[4*s], bkmn_reg[4*s+1], bkmn_reg[4*s+2]);
			o_synth_ok[s] = syn_in_range(num[s], bkmn_reg[4*s+3]);
			for (int d = 0; d < NDIV; d++) begin
				o_div_ok[4*s+d] = div_in_range(num[s], bkmn_reg[4*s+3], div_reg[4*s+d],
					(d < 2) ? FDIFF_MAX : FSE_MAX);
			end
		end
	end

	// ----------------------------------------
	// Master clock strap sampling
	// ----------------------------------------
	logic [1:0] pin_s1_reg;
	logic [1:0] pin_s2_reg;
	sds_st_t    st_reg;
	sds_st_t    st_next;
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic [1:0] sel_reg;
	logic [1:0] sel_next;
	logic       smp_reg;
	logic       smp_next;

	always_comb begin
		st_next  = st_reg;
		cnt_next = cnt_reg + 32'h00000001;
		sel_next = sel_reg;
		smp_next = smp_reg;
		case (st_reg)
			ST_SYNC: begin
				if (cnt_reg == SYNC_CYC - 32'h00000001) begin
					sel_next = pin_s2_reg;
					smp_next = 1'b1;
					st_next  = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (cnt_reg >= 32'(STRAP_CYCLES) - 32'h00000001) begin
					st_next = ST_GPIO;
				end
			end
			default: begin
				cnt_next = cnt_reg;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pin_s1_reg <= 2'b00;
			pin_s2_reg <= 2'b00;
			st_reg     <= ST_SYNC;
			cnt_reg    <= '0;
			sel_reg    <= 2'b00;
			smp_reg    <= 1'b0;
		end else begin
			pin_s1_reg <= i_mclk_sel_pin;
			pin_s2_reg <= pin_s1_reg;
			st_reg     <= st_next;
			cnt_reg    <= cnt_next;
			sel_reg    <= sel_next;
			smp_reg    <= smp_next;
		end
	end

	always_comb begin
		case (sds_mclk_t'(sel_reg))
			MCLK_24M: o_mclk_hz = HZ_24M;
			MCLK_49M: o_mclk_hz = HZ_49M;
			MCLK_20M: o_mclk_hz = HZ_20M;
			default:  o_mclk_hz = '0;
		endcase
		if (!smp_reg) begin
			o_mclk_hz = '0;
		end
	end

	assign o_mclk_sel     = sel_reg;
	assign o_mclk_invalid = smp_reg && (sel_reg == MCLK_RSVD);
	assign o_mclk_valid   = smp_reg && (sel_reg != MCLK_RSVD);
	assign o_strap_window = (st_reg != ST_GPIO);

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	always_comb begin
		rd_val = 32'h00000000;
		if (syn_hit) begin
			case (ix)
				IX_B, IX_K, IX_M, IX_N: rd_val = 32'(bkmn_reg[{sidx, ix[1:0]}]);
				IX_FINE:                rd_val = 32'(fine_reg[sidx]);
				IX_CRS0, IX_CRS1:       rd_val = 32'($signed(crs_reg[{sidx, ix == IX_CRS1}]));
				default:                rd_val = div_reg[{sidx, dix}];
			endcase
		end else if (i_paddr == ADDR_REF) begin
			rd_val = 32'(ref_reg);
		end else if (i_paddr == ADDR_CFO) begin
			rd_val = cfo_reg;
		end else if (i_paddr == ADDR_STAT) begin
			rd_val = {pin_s2_reg, o_div_ok, o_synth_ok, 5'h00, o_strap_window,
				o_mclk_invalid, o_mclk_valid, sel_reg};
		end
		rdata_next = rdata_reg;
		if (i_psel && !i_penable) begin
			rdata_next = rd_val;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rdata_reg <= 32'h00000000;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign o_prdata  = rdata_reg;
	assign o_pready  = i_psel && i_penable;
	assign o_pslverr = i_psel && i_penable && !(syn_hit || glb_hit);

	// ----------------------------------------
	// Output fields
	// ----------------------------------------
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			o_synth_bkmn[16*i +: 16] = bkmn_reg[i];
			o_div_ratio[32*i +: 32]  = div_reg[i];
			o_out_fine[FINE_W*i +: FINE_W] = fine_reg[i/4];
		end
		for (int i = 0; i < 8; i++) begin
			o_se_coarse[CRS_W*i +: CRS_W] = crs_reg[i];
		end
	end

	assign o_ref_diff = ref_reg;
	assign o_cfo      = cfo_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	strap_sample_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(st_reg == ST_SYNC && cnt_reg == SYNC_CYC - 32'h00000001)
		|=> smp_reg && (o_mclk_sel == $past(pin_s2_reg)))
		else $error("select pins not captured at start-up");

	strap_hold_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		$rose(smp_reg) |-> o_strap_window [*3])
		else $error("strap window closed too early");

	mclk_decode_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(o_mclk_valid && o_mclk_sel == MCLK_20M) |-> o_mclk_hz == HZ_20M)
		else $error("wrong master clock frequency");

	rsvd_code_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		o_mclk_invalid |-> (o_mclk_hz == '0) && !o_mclk_valid)
		else $error("reserved select code not flagged");

	ref_write_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_en && i_paddr == ADDR_REF) |=> o_ref_diff == $past(i_pwdata[NREF-1:0]))
		else $error("reference type write lost");

	fine_equal_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		o_out_fine[FINE_W-1:0] == o_out_fine[4*FINE_W-1:3*FINE_W])
		else $error("fine phase differs across outputs");

	coarse_range_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_en && syn_hit && ix == IX_CRS0 && $signed(i_pwdata) > 32'sh1000)
		|=> crs_reg[{$past(sidx), 1'b0}] == CRS_MAX)
		else $error("coarse skew not limited");

	synth_zero_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		(wr_en && syn_hit && ix == IX_N && sidx == 2'b00 && i_pwdata[15:0] == 16'h0000)
		|=> !o_synth_ok[0])
		else $error("zero divisor reported in range");

	div_zero_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
		o_div_ok[0] |-> o_div_ratio[31:0] != 32'h00000000)
		else $error("zero divider reported usable");

endmodule

`default_nettype wire

/* dv/sds_tb.sv */
// Self-checking bench for the synthesizer, divider, skew and master clock control.
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import sds_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic              i_clk  = 1'b0;
	logic              arst_n = 1'b0;
	logic              p_sel  = 1'b0;
	logic              p_en   = 1'b0;
	logic              p_wr   = 1'b0;
	logic [11:0]       p_addr = 12'h000;
	logic [31:0]       p_wd   = 32'h00000000;
	logic [1:0]        pins   = 2'b00;
	logic [31:0]       prd;
	logic              prdy;
	logic              perr;
	logic [1:0]        sel;
	logic [MHZ_W-1:0]  hz;
	logic              vld;
	logic              inv;
	logic              win;
	logic [7:0]        refd;
	logic [31:0]       cfo;
	logic [255:0]      bkmn;
	logic [3:0]        sok;
	logic [511:0]      divr;
	logic [15:0]       dok;
	logic [127:0]      fine;
	logic [111:0]      crs;
	int                err_total = 0;
	int                tests_run = 0;
	int                cyc       = 0;

	sds_synth_ctrl #(.STRAP_CYCLES(20)) dut_u (
		.i_clk(i_clk), .i_arst_n(arst_n), .i_psel(p_sel), .i_penable(p_en),
		.i_pwrite(p_wr), .i_paddr(p_addr), .i_pwdata(p_wd), .o_prdata(prd),
		.o_pready(prdy), .o_pslverr(perr), .i_mclk_sel_pin(pins), .o_mclk_sel(sel),
		.o_mclk_hz(hz), .o_mclk_valid(vld), .o_mclk_invalid(inv), .o_strap_window(win),
		.o_ref_diff(refd), .o_cfo(cfo), .o_synth_bkmn(bkmn), .o_synth_ok(sok),
		.o_div_ratio(divr), .o_div_ok(dok), .o_out_fine(fine), .o_se_coarse(crs)
	);

	always #4 i_clk = ~i_clk;

	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			complete_run();
		end
	end

	// ----------------------------------------
	// Tasks and expectations
	// ----------------------------------------
	task automatic chk(input string nm, input logic [79:0] seen, input logic [79:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
			err_total++;
		end
	endtask

	task automatic complete_run();
		if (err_total == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		@(posedge i_clk);
		p_sel  <= 1'b1;
		p_en   <= 1'b0;
		p_wr   <= w;
		p_addr <= a;
		p_wd   <= d;
		@(posedge i_clk);
		p_en <= 1'b1;
		do @(posedge i_clk); while (prdy !== 1'b1);
		r = prd;
		e = perr;
		p_sel <= 1'b0;
		p_en  <= 1'b0;
	endtask

	function automatic logic [11:0] ra(input int s, input logic [3:0] ix);
		return 12'(s * 64) + {6'h00, ix, 2'b00};
	endfunction

	function automatic logic [79:0] fq(input logic [15:0] b, k, m);
		return FREQ_MUL * b * k * m;
	endfunction

	function automatic logic bad(input logic [15:0] b, k, m, n);
		logic [63:0] p;
		p = 64'(b) * 64'(k) * 64'(m);
		for (int i = 0; i < 7; i++) begin
			if (n != 16'h0000 && p % (64'(n) * (64'h3E80000 + 64'(i) * 64'h3E8000)) == 64'h0) begin
				return 1'b1;
			end
		end
		return 1'b0;
	endfunction

	function automatic logic [13:0] clamp(input logic [31:0] v);
		if ($signed(v) > 4096) return 14'h1000;
		if ($signed(v) < -4096) return 14'h3000;
		return v[13:0];
	endfunction

	function automatic logic [MHZ_W-1:0] hz_of(input logic [1:0] c);
		case (c)
			2'b00: return HZ_24M;
			2'b01: return HZ_49M;
			2'b10: return HZ_20M;
			default: return 26'h0000000;
		endcase
	endfunction

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [15:0] v[4];
		logic [31:0] r;
		logic [31:0] c[2];
		logic [31:0] dv;
		logic [7:0]  f;
		logic [1:0]  code;
		logic        e;
		logic [13:0] cl;
		r = $urandom(59893);
		for (int i = 0; i < 4; i++) begin
			code = 2'(3 - i);
			arst_n <= 1'b0;
			pins <= code;
			repeat (12) @(posedge i_clk);
			arst_n <= 1'b1;
			repeat (6) @(posedge i_clk);
			chk("sel", sel, code);
			chk("hz", hz, hz_of(code));
			chk("valid", vld, code != 2'b11);
			chk("invalid", inv, code == 2'b11);
			chk("window", win, 1'b1);
			repeat (20) @(posedge i_clk);
			chk("window_end", win, 1'b0);
			pins <= ~code;
			repeat (4) @(posedge i_clk);
			chk("sel_held", sel, code);
		end
		apb(1'b0, ADDR_CFO, 32'h00000000, r, e);
		chk("cfo_rst", r, RST_CFO);
		chk("cfo_err", e, 1'b0);
		chk("cfo_out", cfo, RST_CFO);
		apb(1'b0, ADDR_STAT, 32'h00000000, r, e);
		chk("status", r, {2'b11, 16'hFFFF, 4'h0, 5'h00, 1'b0, 1'b0, 1'b1, 2'b00});
		chk("ref_rst", refd, RST_REF);
		apb(1'b0, 12'h000, 32'h00000000, r, e);
		chk("b_rst", r, 32'h00000001);
		apb(1'b0, 12'h10C, 32'h00000000, r, e);
		chk("unmapped_err", e, 1'b1);
		chk("unmapped_data", r, 32'h00000000);
		dv = $urandom;
		apb(1'b1, ADDR_REF, dv, r, e);
		@(posedge i_clk);
		chk("ref_diff", refd, dv[7:0]);
		for (int rep = 0; rep < 3; rep++) begin
			for (int s = 0; s < 4; s++) begin
				v = '{16'hF424, 16'((s == 3) ? 999 : 1000 + s * 250 + (s / 2)), 16'h0001, 16'h0001};
				if (rep == 1) v[1] = 16'($urandom_range(900, 1600));
				if (rep == 2) v = '{16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom)};
				for (int t = 0; t < 64 && bad(v[0], v[1], v[2], v[3]); t++) begin
					v[0] = v[0] + 16'h0001;
					v[1] = v[1] | 16'h0001;
					v[2] = v[2] | 16'h0001;
				end
				for (int x = 0; x < 4; x++) apb(1'b1, ra(s, 4'(x)), {16'h0000, v[x]}, r, e);
				f = 8'($urandom);
				apb(1'b1, ra(s, IX_FINE), {24'h000000, f}, r, e);
				c[0] = (rep == 0) ? 32'h00001388 : 32'($urandom_range(0, 8192)) - 32'd4096;
				c[1] = (rep == 0) ? 32'hFFFFEC78 : $urandom;
				apb(1'b1, ra(s, IX_CRS0), c[0], r, e);
				apb(1'b1, ra(s, IX_CRS1), c[1], r, e);
				for (int d = 0; d < 4; d++) begin
					dv = (rep == 0 && d == 3) ? 32'h00000000 : 32'($urandom_range(1, 12));
					apb(1'b1, ra(s, 4'(IX_DIV0 + d)), dv, r, e);
					@(posedge i_clk);
					chk("div_ratio", divr[32*(4*s+d) +: 32], dv);
					chk("div_ok", dok[4*s+d], dv != 0 && v[3] != 0 && fq(v[0], v[1], v[2])
						<= v[3] * dv * ((d < 2) ? FDIFF_MAX : FSE_MAX));
					chk("fine", fine[8*(4*s+d) +: 8], f);
				end
				for (int x = 0; x < 4; x++) chk("bkmn", bkmn[64*s+16*x +: 16], v[x]);
				chk("synth_ok", sok[s], v[3] != 0 && fq(v[0], v[1], v[2]) >= FSYN_MIN * v[3]
					&& fq(v[0], v[1], v[2]) <= FSYN_MAX * v[3]);
				for (int x = 0; x < 2; x++) chk("coarse", crs[14*(2*s+x) +: 14], clamp(c[x]));
				apb(1'b0, ra(s, IX_CRS1), 32'h00000000, r, e);
				cl = clamp(c[1]);
				chk("coarse_rd", r, {{18{cl[13]}}, cl});
			end
		end
		apb(1'b1, ra(0, IX_N), 32'h00000000, r, e);
		@(posedge i_clk);
		chk("synth_zero", sok[0], 1'b0);
		chk("div_zero_n", dok[0], 1'b0);
		complete_run();
	end

endmodule

`default_nettype wire
